// *** hw/gauge_consts.svh ***
// Register addresses, field positions, reset values and timing counts
`ifndef GAUGE_CONSTS_SVH
`define GAUGE_CONSTS_SVH
`define A_MODE 8'h00
`define A_CTRL 8'h01
`define A_SNAP_LO 8'h02
`define A_SNAP_HI 8'h0B
`define A_ID_LO 8'h18
`define A_ID_HI 8'h1F
`define A_RAM_LO 8'h20
`define A_RAM_HI 8'h3F
`define F_SEL_EXT 0
`define F_CAL 3
`define F_RUN 4
`define F_PIN 0
`define F_GRST 1
`define F_GEOC 2
`define F_VEOC 3
`define F_POR 4
`define MODE_RST 5'h00
`define ADDR_FIXED 4'hE
`define CRC_POLY 8'h07
`define TB_HZ 32768
`define VT_CONV_TICKS 16'h1FFF
`define VT_PERIOD_TICKS 16'hFFFF
`define ACC_W 28
`endif

// *** hw/gauge_pkg.sv ***
// Types shared by the gauge core
package gauge_pkg;
	typedef enum logic [2:0] {
		I2C_IDLE = 3'h0,
		I2C_ADDR = 3'h1,
		I2C_REG = 3'h2,
		I2C_WDATA = 3'h3,
		I2C_RDATA = 3'h4
	} i2c_state_t;
endpackage

// *** hw/gauge_core.sv ***
// Battery gauge digital core with serial slave port
`timescale 1ns/1ps
`include "gauge_consts.svh"
// How it works
// - Add each current result into 28-bit accumulator
// - Host reads only upper 16 accumulator bits
// - Count completed current conversions in 16 bits
// - Keep latest current result, refreshed every conversion
// - Calibration bit shorts current converter inputs
// - Current conversion lasts 2^n timebase ticks
// - Undervoltage halts gauge, keeps register contents
// - Power-on reset restores all default values
// - Timebase from internal oscillator or external clock
// - Voltage, temperature alternate every two seconds
// - Voltage/temperature conversion spans 8192 ticks
// - Voltage 2.44 mV, temperature 0.125 C per code
// - Pin bit 0 drives low, 1 releases
// - Pin bit read returns sampled pin level
// - Inactive states release pin, read it zero
// - 32 RAM bytes survive until power-on reset
// - Eight byte identifier: type, unique number, CRC
// - Identifier CRC-8, polynomial 07h, zero seed
// - Identifier copied into read-only locations at power-up
// - Serial port up to 400 kbit/s, MSB first
// - Slave address 1110, three select bits, R/W
// - Address, register address, data, each acknowledged
// - Resolution code 00/01/10 gives 14/13/12 bits
// - Run bit clear freezes gauge and monitor
// - Gauge reset bit clears accumulator and counter
module gauge_core #(
	parameter logic [7:0] PART_TYPE = 8'hA5, // Arbitrary value
	parameter logic [47:0] UNIQUE_ID = 48'h0123456789AB // Arbitrary value
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic por_in,
	input wire logic uvlo_in,
	input wire logic int_tb_in,
	input wire logic ext_tb_in,
	input wire logic [2:0] address_select_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic gp_in,
	output logic gp_out,
	output logic gp_oe_out,
	input wire logic [15:0] cur_result_in,
	input wire logic [15:0] vt_result_in,
	output logic cal_short_out,
	output logic vt_busy_out,
	output logic vt_sel_out
);
	function automatic logic [7:0] crc8(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 55; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `CRC_POLY : 8'h00);
		end
		return c;
	endfunction
	localparam logic [63:0] ID_IMAGE = {PART_TYPE, UNIQUE_ID,
		crc8({PART_TYPE, UNIQUE_ID})};

	// Pin synchronisers: only the second stage is read
	logic [9:0] s1_q, s2_q;
	always_ff @(posedge ref_clk_in) begin
		s1_q <= {address_select_in, uvlo_in, por_in, ext_tb_in, int_tb_in,
			gp_in, sda_in, scl_in};
		s2_q <= s1_q;
	end
	logic scl_s, sda_s, gp_s, uvlo_s, por_s, rst_all;
	assign scl_s = s2_q[0];
	assign sda_s = s2_q[1];
	assign gp_s = s2_q[2];
	assign por_s = s2_q[5];
	assign uvlo_s = s2_q[6];
	assign rst_all = rst_in | por_s;

	// Host-side state
	gauge_pkg::i2c_state_t state_q, state_d;
	logic [3:0] bitcnt_q, bitcnt_d;
	logic ack_q, ack_d, rw_q, rw_d, nack_q, nack_d, drv_q, drv_d;
	logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d, rd_data;
	logic [4:0] mode_q, mode_d;
	logic pin_q, pin_d, por_flag_q, por_flag_d, grst_q, grst_d;
	logic geoc_q, geoc_d, veoc_q, veoc_d, scl_p_q, sda_p_q;
	logic [7:0] ram_q [0:31];
	logic [7:0] ram_d [0:31];
	logic [7:0] id_q [0:7];
	logic [15:0] snap_q [0:4];
	logic [15:0] snap_d [0:4];
	// Gauge-side state
	logic [27:0] acc_q, acc_d;
	logic [15:0] count_q, count_d, last_q, last_d, volt_q, volt_d;
	logic [15:0] temp_q, temp_d, pcnt_q, pcnt_d;
	logic [13:0] ccnt_q, ccnt_d, len_m1;
	logic vsel_q, vsel_d, gev_q, gev_d, vev_q, vev_d, tb_p_q;
	logic tb_s, tick, on, gend, pin_rd, rd_ctrl;
	logic [15:0] cur_m;

	assign on = mode_q[`F_RUN] & ~por_flag_q & ~uvlo_s;
	assign tb_s = mode_q[`F_SEL_EXT] ? s2_q[4] : s2_q[3];
	assign tick = tb_s & ~tb_p_q;
	assign pin_rd = gp_s & on;

	always_comb begin
		case (mode_q[2:1])
			2'b00: len_m1 = 14'h3FFF;
			2'b01: len_m1 = 14'h1FFF;
			default: len_m1 = 14'h0FFF;
		endcase
	end
	// Low bits vanish at reduced resolution: bit0 below 14, bit1 at 12
	assign cur_m = cur_result_in & ~{14'h0000, ~len_m1[12], ~len_m1[13]};
	assign gend = on & tick & (ccnt_q == len_m1);

	always_comb begin
		acc_d = acc_q;
		count_d = count_q;
		last_d = last_q;
		ccnt_d = ccnt_q;
		pcnt_d = pcnt_q;
		vsel_d = vsel_q;
		volt_d = volt_q;
		temp_d = temp_q;
		gev_d = 1'b0;
		vev_d = 1'b0;
		if (on && tick) begin
			ccnt_d = gend ? 14'h0000 : ccnt_q + 14'h0001;
			pcnt_d = pcnt_q + 16'h0001;
			if (gend) begin
				acc_d = acc_q + {{12{cur_m[15]}}, cur_m};
				count_d = count_q + 16'h0001;
				last_d = cur_m;
				gev_d = 1'b1;
			end
			if (pcnt_q == `VT_CONV_TICKS) begin
				// Raw codes: 2.44 mV or 0.125 C per step
				if (vsel_q) temp_d = vt_result_in;
				else volt_d = vt_result_in;
				vev_d = 1'b1;
			end
			if (pcnt_q == `VT_PERIOD_TICKS) vsel_d = ~vsel_q;
		end
		if (grst_q) begin
			acc_d = 28'h0000000;
			count_d = 16'h0000;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		tb_p_q <= tb_s;
		if (rst_all) begin
			acc_q <= 28'h0000000;
			count_q <= 16'h0000;
			last_q <= 16'h0000;
			ccnt_q <= 14'h0000;
			pcnt_q <= 16'h0000;
			vsel_q <= 1'b0;
			volt_q <= 16'h0000;
			temp_q <= 16'h0000;
			gev_q <= 1'b0;
			vev_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			count_q <= count_d;
			last_q <= last_d;
			ccnt_q <= ccnt_d;
			pcnt_q <= pcnt_d;
			vsel_q <= vsel_d;
			volt_q <= volt_d;
			temp_q <= temp_d;
			gev_q <= gev_d;
			vev_q <= vev_d;
		end
	end

	always_comb begin
		rd_data = 8'h00;
		if (ptr_q == `A_MODE) rd_data = {3'h0, mode_q};
		else if (ptr_q == `A_CTRL)
			rd_data = {3'h0, por_flag_q, veoc_q, geoc_q, 1'b0, pin_rd};
		else if (ptr_q >= `A_SNAP_LO && ptr_q <= `A_SNAP_HI)
			rd_data = ptr_q[0] ? snap_q[3'((ptr_q - 8'h02) >> 1)][15:8]
				: snap_q[3'((ptr_q - 8'h02) >> 1)][7:0];
		else if (ptr_q >= `A_ID_LO && ptr_q <= `A_ID_HI)
			rd_data = id_q[ptr_q[2:0]];
		else if (ptr_q >= `A_RAM_LO && ptr_q <= `A_RAM_HI)
			rd_data = ram_q[ptr_q[4:0]];
	end

	always_comb begin
		logic start, stop, rise, fall, load;
		start = scl_s & sda_p_q & ~sda_s;
		stop = scl_s & ~sda_p_q & sda_s;
		rise = scl_s & ~scl_p_q;
		fall = ~scl_s & scl_p_q;
		load = 1'b0;
		state_d = state_q;
		bitcnt_d = bitcnt_q;
		ack_d = ack_q;
		rw_d = rw_q;
		nack_d = nack_q;
		drv_d = drv_q;
		sh_d = sh_q;
		tx_d = tx_q;
		ptr_d = ptr_q;
		mode_d = mode_q;
		pin_d = pin_q;
		por_flag_d = por_flag_q;
		grst_d = 1'b0;
		ram_d = ram_q;
		snap_d = snap_q;
		rd_ctrl = 1'b0;
		if (start) begin
			state_d = gauge_pkg::I2C_ADDR;
			bitcnt_d = 4'h0;
			ack_d = 1'b0;
			drv_d = 1'b0;
			// One snapshot per start condition, repeated start included, keeps multi-byte values whole
			snap_d[0] = acc_q[27:12];
			snap_d[1] = count_q;
			snap_d[2] = last_q;
			snap_d[3] = volt_q;
			snap_d[4] = temp_q;
		end else if (stop) begin
			state_d = gauge_pkg::I2C_IDLE;
			ack_d = 1'b0;
			drv_d = 1'b0;
		end else if (state_q != gauge_pkg::I2C_IDLE && rise) begin
			if (ack_q) nack_d = sda_s;
			else begin
				sh_d = {sh_q[6:0], sda_s};
				bitcnt_d = bitcnt_q + 4'h1;
			end
		end else if (state_q != gauge_pkg::I2C_IDLE && fall) begin
			if (!ack_q && bitcnt_q == 4'h8) begin
				ack_d = 1'b1;
				drv_d = (state_q != gauge_pkg::I2C_RDATA);
				case (state_q)
					gauge_pkg::I2C_ADDR: begin
						if (sh_q[7:1] == {`ADDR_FIXED, s2_q[9:7]}) begin
							rw_d = sh_q[0];
						end else begin
							state_d = gauge_pkg::I2C_IDLE;
							ack_d = 1'b0;
							drv_d = 1'b0;
						end
					end
					gauge_pkg::I2C_REG: ptr_d = sh_q;
					gauge_pkg::I2C_WDATA: begin
						ptr_d = ptr_q + 8'h01;
						if (ptr_q == `A_MODE) mode_d = sh_q[4:0];
						else if (ptr_q == `A_CTRL) begin
							pin_d = sh_q[`F_PIN];
							grst_d = sh_q[`F_GRST];
							por_flag_d = sh_q[`F_POR];
						end else if (ptr_q >= `A_RAM_LO && ptr_q <= `A_RAM_HI)
							ram_d[ptr_q[4:0]] = sh_q;
					end
					default: ;
				endcase
			end else if (ack_q) begin
				ack_d = 1'b0;
				bitcnt_d = 4'h0;
				drv_d = 1'b0;
				case (state_q)
					gauge_pkg::I2C_ADDR: begin
						state_d = rw_q ? gauge_pkg::I2C_RDATA : gauge_pkg::I2C_REG;
						load = rw_q;
					end
					gauge_pkg::I2C_REG: state_d = gauge_pkg::I2C_WDATA;
					gauge_pkg::I2C_RDATA: begin
						if (nack_q) state_d = gauge_pkg::I2C_IDLE;
						load = ~nack_q;
					end
					default: ;
				endcase
			end else if (state_q == gauge_pkg::I2C_RDATA) begin
				tx_d = {tx_q[6:0], 1'b0};
				drv_d = ~tx_q[6];
			end
			if (load) begin
				tx_d = rd_data;
				drv_d = ~rd_data[7];
				ptr_d = ptr_q + 8'h01;
				rd_ctrl = (ptr_q == `A_CTRL);
			end
		end
		// A completion landing on the read still sets the flag
		geoc_d = (geoc_q & ~rd_ctrl) | gev_q;
		veoc_d = (veoc_q & ~rd_ctrl) | vev_q;
	end

	always_ff @(posedge ref_clk_in) begin
		scl_p_q <= scl_s;
		sda_p_q <= sda_s;
		if (rst_all) begin
			state_q <= gauge_pkg::I2C_IDLE;
			bitcnt_q <= 4'h0;
			ack_q <= 1'b0;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			drv_q <= 1'b0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			mode_q <= `MODE_RST;
			pin_q <= 1'b1;
			por_flag_q <= 1'b1;
			grst_q <= 1'b0;
			geoc_q <= 1'b1;
			veoc_q <= 1'b1;
			for (int i = 0; i < 32; i++) ram_q[i] <= 8'h00;
			for (int i = 0; i < 8; i++) begin
				id_q[i] <= ID_IMAGE[63 - 8 * i -: 8];
			end
			for (int i = 0; i < 5; i++) snap_q[i] <= 16'h0000;
		end else begin
			state_q <= state_d;
			bitcnt_q <= bitcnt_d;
			ack_q <= ack_d;
			rw_q <= rw_d;
			nack_q <= nack_d;
			drv_q <= drv_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			mode_q <= mode_d;
			pin_q <= pin_d;
			por_flag_q <= por_flag_d;
			grst_q <= grst_d;
			geoc_q <= geoc_d;
			veoc_q <= veoc_d;
			ram_q <= ram_d;
			snap_q <= snap_d;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe_out = drv_q;
	assign gp_out = 1'b0;
	assign gp_oe_out = ~pin_q & on;
	assign cal_short_out = mode_q[`F_CAL];
	assign vt_busy_out = on & (pcnt_q <= `VT_CONV_TICKS);
	assign vt_sel_out = vsel_q;

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_all);
	a_acc_add: assert property (gend && !grst_q |=>
		acc_q == $past(acc_q) + {{12{$past(cur_m[15])}}, $past(cur_m)})
		else $error("accumulator missed a conversion");
	a_cnt_step: assert property (gend && !grst_q |=>
		count_q == $past(count_q) + 16'h0001 && last_q == $past(cur_m))
		else $error("counter or last current not updated");
	a_conv_len: assert property (gend |-> ccnt_q == len_m1)
		else $error("conversion ended at wrong length");
	a_uvlo_hold: assert property (uvlo_s && !grst_q |=>
		$stable(acc_q) && $stable(count_q))
		else $error("gauge moved during undervoltage");
	// The power-on input is itself a reset, so this one must not be disabled
	a_por_default: assert property (@(posedge ref_clk_in)
		disable iff (1'b0)
		por_s |=> por_flag_q && mode_q == `MODE_RST && pin_q
		&& ram_q[0] == 8'h00)
		else $error("power-on defaults not restored");
	a_gauge_clr: assert property (grst_q |=>
		acc_q == 28'h0000000 && count_q == 16'h0000)
		else $error("gauge reset did not clear");
	a_vt_window: assert property ($fell(vt_busy_out) && on |->
		pcnt_q == `VT_CONV_TICKS + 16'h0001)
		else $error("voltage window length wrong");
	a_pin_release: assert property (!on |-> !gp_oe_out && !pin_rd)
		else $error("pin active while gauge inactive");
	a_addr_ack: assert property (state_q == gauge_pkg::I2C_ADDR && ack_q
		|-> sda_oe_out && rw_q == sh_q[0]
		&& sh_q[7:1] == {`ADDR_FIXED, s2_q[9:7]})
		else $error("acknowledged a foreign address");
endmodule // gauge_core

// *** tb/i2c_host_model.sv ***
// Behavioural serial bus master that reaches the gauge core
`timescale 1ns/1ps
module i2c_host_model (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_pull_out
);
	initial begin
		scl_out = 1'b1;
		sda_pull_out = 1'b0;
	end
	// Three phases of 42 clocks keep the bit rate just under 400 kbit/s
	task automatic hp();
		repeat (42) @(posedge clk_in);
		#1;
	endtask
	task automatic bit_x(input logic b, output logic r);
		sda_pull_out = !b;
		hp();
		scl_out = 1'b1;
		hp();
		r = sda_in;
		scl_out = 1'b0;
		hp();
	endtask
	task automatic start();
		// Release data before raising the clock, so a repeat start
		// never looks like a stop
		sda_pull_out = 1'b0;
		hp();
		scl_out = 1'b1;
		hp();
		sda_pull_out = 1'b1;
		hp();
		scl_out = 1'b0;
		hp();
	endtask
	task automatic stop();
		sda_pull_out = 1'b1;
		hp();
		scl_out = 1'b1;
		hp();
		sda_pull_out = 1'b0;
		hp();
	endtask
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = !r;
	endtask
	task automatic get(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(!ack, r);
	endtask
endmodule // i2c_host_model

// *** tb/test_battery_gauge_digital_core.sv ***
// Self-checking bench for the gauge core
`timescale 1ns/1ps
module test_battery_gauge_digital_core;
	localparam logic [7:0] PT = 8'h3C; // Arbitrary value
	localparam logic [47:0] UID = 48'hC0FFEE123456; // Arbitrary value
	localparam logic [2:0] SEL = 3'h5;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic por = 1'b0;
	logic uvlo = 1'b0;
	logic tb = 1'b0;
	logic gp_ext = 1'b1;
	logic scl, pull, sda, sda_oe, gp_oe, gp, cal, busy;
	logic sda_o, gp_o, vsel;
	logic [7:0] rb [0:7];
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	int t0;
	always #10 clk = !clk;
	always #80 tb = !tb;
	always @(posedge clk) cyc <= cyc + 1;
	// Pull-ups: a released line reads high
	assign sda = !(pull | (sda_oe & !sda_o));
	assign gp = (gp_oe & !gp_o) ? 1'b0 : gp_ext;
	i2c_host_model host (.clk_in(clk), .sda_in(sda), .scl_out(scl),
		.sda_pull_out(pull));
	gauge_core #(.PART_TYPE(PT), .UNIQUE_ID(UID)) DUT (
		.ref_clk_in(clk), .rst_in(rst), .por_in(por), .uvlo_in(uvlo),
		.int_tb_in(tb), .ext_tb_in(tb), .address_select_in(SEL),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
		.gp_in(gp), .gp_out(gp_o), .gp_oe_out(gp_oe),
		.cur_result_in(16'h7FFC), .vt_result_in(16'h1234),
		.cal_short_out(cal), .vt_busy_out(busy), .vt_sel_out(vsel));
	function automatic logic [7:0] crc8(input logic [55:0] m);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 55; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n);
		logic k;
		host.start();
		host.put({4'hE, SEL, 1'b0}, k);
		chk(16'(k), 16'h1);
		host.put(a, k);
		chk(16'(k), 16'h1);
		for (int i = 0; i < n; i++) begin
			host.put(d + 8'(i), k);
			chk(16'(k), 16'h1);
		end
		host.stop();
	endtask
	task automatic rd(input logic [7:0] a, input int n);
		logic k;
		host.start();
		host.put({4'hE, SEL, 1'b0}, k);
		host.put(a, k);
		host.start();
		host.put({4'hE, SEL, 1'b1}, k);
		chk(16'(k), 16'h1);
		for (int i = 0; i < n; i++) host.get(i < n - 1, rb[i]);
		host.stop();
	endtask
	task automatic t_reset();
		rd(8'h01, 1);
		chk(16'(rb[0]), 16'h001C);
		chk(16'({gp_oe, busy, cal, vsel}), 16'h0);
	endtask
	task automatic t_bad();
		logic k;
		host.start();
		host.put({4'hE, 3'h2, 1'b0}, k);
		host.stop();
		chk(16'(k), 16'h0);
	endtask
	task automatic t_on();
		wr(8'h01, 8'h00, 1);
		chk(16'(gp_oe), 16'h0);
		wr(8'h00, 8'h1C, 1);
		t0 = cyc;
		chk(16'({gp_oe, cal}), 16'h3);
	endtask
	task automatic t_pin();
		wr(8'h01, 8'h01, 1);
		chk(16'(gp_oe), 16'h0);
		rd(8'h01, 1);
		chk(16'(rb[0] & 8'h11), 16'h01);
		gp_ext = 1'b0;
		rd(8'h01, 1);
		chk(16'(rb[0] & 8'h11), 16'h00);
		gp_ext = 1'b1;
	endtask
	task automatic t_ram();
		wr(8'h20, 8'h5A, 3);
		rd(8'h20, 3);
		for (int i = 0; i < 3; i++) chk(16'(rb[i]), 16'(8'h5A + i));
	endtask
	task automatic t_id();
		logic [63:0] m;
		wr(8'h18, 8'h00, 1);
		m = {PT, UID, crc8({PT, UID})};
		rd(8'h18, 8);
		for (int i = 0; i < 8; i++)
			chk(16'(rb[i]), 16'(m[63 - 8 * i -: 8]));
	endtask
	// Conversion phase is not known exactly, so one or two may have ended
	task automatic t_gauge();
		int n;
		while (cyc < t0 + 40000) @(posedge clk);
		#1;
		rd(8'h02, 6);
		n = {rb[3], rb[2]};
		if (n < 1 || n > 2) chk(16'(n), 16'h1);
		chk({rb[1], rb[0]}, 16'((n * 32764) >> 12));
		chk({rb[5], rb[4]}, 16'h7FFC);
	endtask
	task automatic t_grst();
		int n;
		wr(8'h01, 8'h03, 1);
		rd(8'h02, 4);
		n = {rb[3], rb[2]};
		chk(16'(n > 1), 16'h0);
		chk({rb[1], rb[0]}, 16'((n * 32764) >> 12));
	endtask
	task automatic t_uvlo();
		wr(8'h01, 8'h00, 1);
		chk(16'(gp_oe), 16'h1);
		uvlo = 1'b1;
		repeat (8) @(posedge clk);
		#1;
		chk(16'(gp_oe), 16'h0);
		rd(8'h20, 1);
		chk(16'(rb[0]), 16'h005A);
		uvlo = 1'b0;
	endtask
	task automatic t_por();
		por = 1'b1;
		repeat (5) @(posedge clk);
		#1;
		por = 1'b0;
		rd(8'h20, 1);
		chk(16'(rb[0]), 16'h0000);
		rd(8'h01, 1);
		chk(16'(rb[0]), 16'h001C);
	endtask
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_bad();
		t_on();
		t_pin();
		t_ram();
		t_id();
		t_gauge();
		t_grst();
		t_uvlo();
		t_por();
		close_out();
	end
	initial begin
		repeat (150000) @(posedge clk);
		err_total++;
		close_out();
	end
endmodule // test_battery_gauge_digital_core
